// [bbce_pkg.sv]
package bbce_pkg;
  // opcode nibbles of the handled group
  localparam logic [3:0] OP_BIT_SET = 4'h8;
  localparam logic [3:0] OP_BIT_TOGGLE = 4'h7;
  localparam logic [3:0] OP_SKIP_CLEAR = 4'hB;
  localparam logic [3:0] OP_SKIP_SET = 4'hA;
  localparam logic [3:0] OP_BRANCH_GRP = 4'hE;
  localparam logic [3:0] OP_SECOND_WORD = 4'hF;
  // second nibble of the branch and call words
  localparam logic [3:0] SUB_BRANCH_ZERO = 4'h0;
  localparam logic [3:0] SUB_BRANCH_OVF = 4'h4;
  localparam logic [2:0] SUB_CALL_TOP = 3'h6;
  // field positions inside the instruction word
  localparam int BIT_IDX_LSB = 9;
  localparam int ACCESS_BIT = 8;
  localparam int SHADOW_BIT = 8;
  // widths and reset values
  localparam int PC_W = 21;
  localparam logic [20:0] PC_RESET = 21'h000000;
  localparam logic [20:0] PC_STEP = 21'h000002;
  localparam logic [20:0] RET_STEP = 21'h000004;
  localparam logic [3:0] BANK_ACCESS = 4'h0;
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] BANK_HIGH = 4'hF;
  // execution states
  typedef enum logic [1:0] {
    BBCE_EXEC = 2'b00,
    BBCE_FLUSH = 2'b01,
    BBCE_CALL2 = 2'b10
  } bbce_state_t;
endpackage

// [bbce_addr_gen.sv]
`timescale 1ns/10ps
// forms the 12-bit data address from access bit, bank select and offset
module bbce_addr_gen
  import bbce_pkg::*;
(
  // operand fields
  input wire logic accessSel,
  input wire logic [7:0] fileOffset,
  // bank state
  input wire logic [3:0] bankSelect,
  // result
  output logic [11:0] dataAddr
);
  // access bank: low half in bank 0, high half in the top bank
  wire logic [3:0] accessBank = (fileOffset < ACCESS_SPLIT) ? BANK_ACCESS : BANK_HIGH;
  assign dataAddr = {accessSel ? bankSelect : accessBank, fileOffset};
endmodule

// [bit_branch_call_exec.sv]
`timescale 1ns/10ps
module bit_branch_call_exec
  import bbce_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // instruction fetch, one word per instruction cycle
  input wire logic [15:0] instrWord,
  input wire logic instrValid,
  // data register file
  input wire logic [7:0] fileRdData,
  output logic [11:0] fileAddr,
  output logic fileWrEn,
  output logic [7:0] fileWrData,
  // core registers
  input wire logic [7:0] workingReg,
  input wire logic [7:0] statusReg,
  input wire logic [7:0] bankSelectReg,
  input wire logic flagOverflow,
  input wire logic flagZero,
  // program counter and return stack
  output logic [20:0] pcOut,
  output logic [20:0] topOfReturnStack,
  output logic pushStrobe,
  // shadow registers
  output logic [7:0] workingShadow,
  output logic [7:0] flagsShadow,
  output logic [7:0] bankSelectShadow,
  // status
  output logic execNop,
  output logic statusWrEn
);
  // state
  bbce_state_t state_ff, nxt_state;
  logic [20:0] pc_ff, nxt_pc;
  logic [1:0] flushCnt_ff, nxt_flushCnt;
  logic [7:0] callLow_ff; // target bits 7..0 held over
  logic brFlushOnly_ff; // current flush follows a taken branch
  logic [20:0] tos_ff;
  logic push_ff;
  logic [7:0] ws_ff, ss_ff, bs_ff;

  // advance by the given byte step
  function automatic logic [20:0] pcInc(input logic [20:0] p, input logic [20:0] s);
    pcInc = p + s;
  endfunction

  // decode of the first word
  wire logic [3:0] opHi = instrWord[15:12];
  wire logic [3:0] opSub = instrWord[11:8];
  wire logic [2:0] bitIdx = instrWord[11:BIT_IDX_LSB];
  wire logic inExec = (state_ff == BBCE_EXEC) && instrValid;
  wire logic isBitSet = inExec && (opHi == OP_BIT_SET);
  wire logic isBitTog = inExec && (opHi == OP_BIT_TOGGLE);
  wire logic isSkipClr = inExec && (opHi == OP_SKIP_CLEAR);
  wire logic isSkipSet = inExec && (opHi == OP_SKIP_SET);
  wire logic isBrGrp = inExec && (opHi == OP_BRANCH_GRP);
  wire logic isBrZero = isBrGrp && (opSub == SUB_BRANCH_ZERO);
  wire logic isBrOvf = isBrGrp && (opSub == SUB_BRANCH_OVF);
  wire logic isCall = isBrGrp && (opSub[3:1] == SUB_CALL_TOP);
  // second word of a call when it arrives
  wire logic isCall2 = (state_ff == BBCE_CALL2) && instrValid && (opHi == OP_SECOND_WORD);

  // address formation
  bbce_addr_gen u_addr (
    .accessSel(instrWord[ACCESS_BIT]),
    .fileOffset(instrWord[7:0]),
    .bankSelect(bankSelectReg[3:0]),
    .dataAddr(fileAddr)
  );

  // bit operations on the fetched register
  wire logic [7:0] bitMask = 8'h01 << bitIdx;
  wire logic testBit = |(fileRdData & bitMask);
  wire logic skipHit = (isSkipClr && !testBit) || (isSkipSet && testBit);
  assign fileWrEn = isBitSet || isBitTog;
  assign fileWrData = isBitSet ? (fileRdData | bitMask)
                               : (fileRdData ^ bitMask);

  // branch condition and target
  wire logic brTaken = (isBrOvf && flagOverflow) || (isBrZero && flagZero);
  wire logic [20:0] pcNext = pcInc(pc_ff, PC_STEP);
  wire logic [20:0] offsetX2 = {{12{instrWord[7]}}, instrWord[7:0], 1'b0};
  wire logic [20:0] brTarget = pcInc(pcNext, offsetX2);

  // next-state logic
  always_comb begin
    nxt_state = state_ff;
    nxt_pc = pc_ff;
    nxt_flushCnt = flushCnt_ff;
    unique case (state_ff)
      BBCE_EXEC: begin
        if (instrValid) begin
          nxt_pc = pcNext;
          if (brTaken) begin
            nxt_pc = brTarget;
            nxt_state = BBCE_FLUSH;
            nxt_flushCnt = 2'h1;
          end else if (skipHit) begin
            nxt_state = BBCE_FLUSH;
            nxt_flushCnt = 2'h1;
          end else if (isCall) begin
            nxt_state = BBCE_CALL2;
          end
        end
      end
      BBCE_FLUSH: begin
        if (instrValid) begin
          // a skipped word advances the counter; a branch target is held
          if (!brFlushOnly_ff) begin
            nxt_pc = pcNext;
          end
          if (flushCnt_ff == 2'h1 && (opHi == OP_BRANCH_GRP) && (opSub[3:1] == SUB_CALL_TOP)
              && !brFlushOnly_ff) begin
            nxt_flushCnt = 2'h2; // two-word skip
          end else begin
            nxt_state = BBCE_EXEC;
            nxt_flushCnt = 2'h0;
          end
        end
      end
      BBCE_CALL2: begin
        if (isCall2) begin
          nxt_pc = {instrWord[11:0], callLow_ff, 1'b0};
          nxt_state = BBCE_EXEC;
        end
      end
      default: begin
        nxt_state = BBCE_EXEC;
      end
    endcase
  end

  // flush caused by a branch never extends and keeps the target
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      brFlushOnly_ff <= 1'b0;
    end else if (inExec) begin
      brFlushOnly_ff <= brTaken;
    end
  end

  // sequencing registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= BBCE_EXEC;
      pc_ff <= PC_RESET;
      flushCnt_ff <= 2'h0;
    end else begin
      state_ff <= nxt_state;
      pc_ff <= nxt_pc;
      flushCnt_ff <= nxt_flushCnt;
    end
  end

  // call first word capture and push
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      callLow_ff <= 8'h00;
      tos_ff <= PC_RESET;
      push_ff <= 1'b0;
    end else begin
      push_ff <= isCall;
      if (isCall) begin
        callLow_ff <= instrWord[7:0];
        tos_ff <= pcInc(pc_ff, RET_STEP);
      end
    end
  end

  // shadow copies on a call with shadow bit set
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ws_ff <= 8'h00;
      ss_ff <= 8'h00;
      bs_ff <= 8'h00;
    end else if (isCall && instrWord[SHADOW_BIT]) begin
      ws_ff <= workingReg;
      ss_ff <= statusReg;
      bs_ff <= bankSelectReg;
    end
  end

  // outputs
  assign pcOut = pc_ff;
  assign topOfReturnStack = tos_ff;
  assign pushStrobe = push_ff;
  assign workingShadow = ws_ff;
  assign flagsShadow = ss_ff;
  assign bankSelectShadow = bs_ff;
  assign execNop = (state_ff == BBCE_FLUSH);
  assign statusWrEn = 1'b0;

  // checks
  AST_SET_WRITES_ONE: assert property (@(posedge clk) disable iff (sys_rst)
    isBitSet |-> fileWrEn && ((fileWrData & bitMask) == bitMask))
    else $error("bit set did not write one");
  AST_TOGGLE_INVERTS: assert property (@(posedge clk) disable iff (sys_rst)
    isBitTog |-> fileWrEn && ((fileWrData ^ fileRdData) == bitMask))
    else $error("toggle did not invert one bit");
  AST_SKIP_NOP: assert property (@(posedge clk) disable iff (sys_rst)
    skipHit |=> execNop)
    else $error("skip did not insert no-operation");
  AST_NO_SKIP_ONE: assert property (@(posedge clk) disable iff (sys_rst)
    (isSkipClr || isSkipSet) && !skipHit |=> !execNop)
    else $error("non-skip took extra cycle");
  AST_BRANCH_TARGET: assert property (@(posedge clk) disable iff (sys_rst)
    brTaken |=> pc_ff == $past(brTarget))
    else $error("branch target wrong");
  AST_BRANCH_NOT_TAKEN: assert property (@(posedge clk) disable iff (sys_rst)
    isBrOvf && !flagOverflow |=> pc_ff == $past(pcNext) && !execNop)
    else $error("overflow branch taken wrongly");
  AST_PUSH_RET: assert property (@(posedge clk) disable iff (sys_rst)
    isCall |=> pushStrobe && topOfReturnStack == $past(pc_ff) + RET_STEP)
    else $error("return address wrong");
  AST_PC_EVEN: assert property (@(posedge clk) disable iff (sys_rst)
    pc_ff[0] == 1'b0)
    else $error("odd program counter");
  AST_NO_FLAGS: assert property (@(posedge clk) disable iff (sys_rst)
    !statusWrEn)
    else $error("status flags written");
  // branch flush cycle, and a skip that lands on a call first word
  sequence seqBranchFlush;
    brTaken ##1 (execNop && instrValid);
  endsequence
  sequence seqSkipCallWord;
    skipHit ##1 (instrValid && (opHi == OP_BRANCH_GRP) && (opSub[3:1] == SUB_CALL_TOP));
  endsequence
  AST_BRANCH_HOLDS_TARGET: assert property (@(posedge clk) disable iff (sys_rst)
    seqBranchFlush |=> pc_ff == $past(pc_ff))
    else $error("taken branch left its target");
  AST_SKIP_TWO_WORD: assert property (@(posedge clk) disable iff (sys_rst)
    seqSkipCallWord |=> execNop)
    else $error("two-word skip lacked second no-operation");
  AST_SHADOW_KEEP: assert property (@(posedge clk) disable iff (sys_rst)
    isCall && !instrWord[SHADOW_BIT] |=> $stable(workingShadow) && $stable(flagsShadow)
      && $stable(bankSelectShadow))
    else $error("shadow changed without shadow bit");
  AST_ZERO_NOT_TAKEN: assert property (@(posedge clk) disable iff (sys_rst)
    isBrZero && !flagZero |=> pc_ff == $past(pcNext) && !execNop)
    else $error("zero branch taken wrongly");
endmodule

// [bbce_file_model.sv]
`timescale 1ns/10ps
// banked data register file facing the decoder
module bbce_file_model (
  // clock
  input wire logic clk,
  // access port
  input wire logic [11:0] fileAddr,
  input wire logic fileWrEn,
  input wire logic [7:0] fileWrData,
  output logic [7:0] fileRdData
);
  logic [7:0] mem [4096]; // register contents
  // distinct start pattern so wrong addresses show up
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i * 37 + 5);
    end
  end
  // combinational read of the addressed register
  assign fileRdData = mem[fileAddr];
  // write-back at the end of the cycle
  always @(posedge clk) begin
    if (fileWrEn) begin
      mem[fileAddr] <= fileWrData;
    end
  end
endmodule

// [bit_branch_call_exec_bench.sv]
`timescale 1ns/10ps
// random and corner-case bench for the bit, branch and call decoder
module bit_branch_call_exec_bench
  import bbce_pkg::*;
;
  logic clk, sys_rst, instrValid, flagOverflow, flagZero, fileWrEn, pushStrobe;
  logic execNop, statusWrEn, ov, zr, known;
  logic [15:0] instrWord;
  logic [7:0] workingReg, statusReg, bankSelectReg, fileRdData, fileWrData, old;
  logic [7:0] workingShadow, flagsShadow, bankSelectShadow, eW, eF, eB, wr, sr, bank_select_reg;
  logic [11:0] fileAddr;
  logic [20:0] pcOut, topOfReturnStack, ep;
  int fails, comparisons;
  bit_branch_call_exec u_bit_branch_call_exec (.clk, .sys_rst, .instrWord, .instrValid,
    .fileRdData, .fileAddr, .fileWrEn, .fileWrData, .workingReg, .statusReg,
    .bankSelectReg, .flagOverflow, .flagZero, .pcOut, .topOfReturnStack, .pushStrobe,
    .workingShadow, .flagsShadow, .bankSelectShadow, .execNop, .statusWrEn);
  bbce_file_model u_bbce_file_model (.clk, .fileAddr, .fileWrEn, .fileWrData, .fileRdData);
  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic check(string what, logic [20:0] seen, logic [20:0] want);
    comparisons++;
    if (seen !== want) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_sim();
    $display("fails %0d comparisons %0d", fails, comparisons);
    if (fails == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // expected data address: access bank splits at 0x80
  function automatic logic [11:0] addr_of(logic a, logic [7:0] f, logic [7:0] bs);
    if (a) return {bs[3:0], f};
    return {(f < 8'h80) ? 4'h0 : 4'hF, f};
  endfunction
  // present one word at the edge, optionally with fresh core inputs, then settle
  task automatic step(logic [15:0] w, logic rnd);
    @(posedge clk);
    if (rnd) begin
      ov = 1'($urandom);
      zr = 1'($urandom);
      wr = 8'($urandom);
      sr = 8'($urandom);
      bank_select_reg = 8'($urandom);
    end
    instrWord <= w;
    instrValid <= 1'b1;
    flagOverflow <= ov;
    flagZero <= zr;
    workingReg <= wr;
    statusReg <= sr;
    bankSelectReg <= bank_select_reg;
    #2;
  endtask
  // two-word call, inputs held over both words
  task automatic call(logic [19:0] k, logic s);
    step({OP_BRANCH_GRP, SUB_CALL_TOP, s, k[7:0]}, 1'b1);
    check("nop0", execNop, 0);
    if (s) begin
      eW = wr;
      eF = sr;
      eB = bank_select_reg;
    end
    step({OP_SECOND_WORD, k[19:8]}, 1'b0);
    check("push", pushStrobe, 1);
    if (known) check("tos", topOfReturnStack, ep + 21'h4);
    step(16'h0000, 1'b1);
    check("pc", pcOut, {k, 1'b0});
    check("push1", pushStrobe, 0);
    check("wsh", workingShadow, eW);
    check("fsh", flagsShadow, eF);
    check("bsh", bankSelectShadow, eB);
    ep = {k, 1'b0} + 21'h2;
    known = 1'b1;
  endtask
  // one group instruction followed by a word that may be discarded
  task automatic run_op(int kind, logic [7:0] n);
    logic [2:0] b;
    logic a, hit, tw;
    logic [7:0] f;
    logic [11:0] ad;
    logic [20:0] tgt;
    b = 3'($urandom);
    a = 1'($urandom);
    f = 8'($urandom);
    tw = kind inside {2, 3} && $urandom % 2;
    case (kind)
      0: step({OP_BIT_SET, b, a, f}, 1'b1);
      1: step({OP_BIT_TOGGLE, b, a, f}, 1'b1);
      2: step({OP_SKIP_CLEAR, b, a, f}, 1'b1);
      3: step({OP_SKIP_SET, b, a, f}, 1'b1);
      4: step({OP_BRANCH_GRP, SUB_BRANCH_OVF, n}, 1'b1);
      default: step({OP_BRANCH_GRP, SUB_BRANCH_ZERO, n}, 1'b1);
    endcase
    ad = addr_of(a, f, bank_select_reg);
    old = u_bbce_file_model.mem[ad];
    hit = kind == 2 ? !old[b] : kind == 3 ? old[b] : kind == 4 ? ov : kind == 5 && zr;
    if (kind < 4) check("addr", fileAddr, ad);
    if (kind == 0) check("set", fileWrData, old | 8'h01 << b);
    if (kind == 1) check("flip", fileWrData, old ^ 8'h01 << b);
    check("wr", fileWrEn, kind < 2);
    check("stat", statusWrEn, 0);
    tgt = ep + 21'h2 + (hit && kind > 3 ? {{12{n[7]}}, n, 1'b0} : 21'h0);
    step(tw ? {OP_BRANCH_GRP, SUB_CALL_TOP, 1'b0, f} : {OP_BIT_SET, b, a, f}, 1'b1);
    check("nop", execNop, hit);
    if (!tw) check("wr2", fileWrEn, !hit);
    if (known) check("pc", pcOut, tgt);
    check("pc0", pcOut[0], 0);
    if (tw) begin
      step({OP_SECOND_WORD, 12'h000}, 1'b1);
      check("nop3", execNop, hit);
    end
    // next instruction: past skipped words, at the branch target, or at the call
    if (tw) begin
      ep = hit ? ep + 21'h6 : {12'h000, f, 1'b0};
    end else begin
      ep = (hit && kind > 3) ? tgt : ep + 21'h4;
    end
    known = 1'b1;
  endtask
  // watchdog against a hung run
  initial begin
    #50000;
    fails++;
    end_sim();
  end
  // main sequence: corner offsets first, then random mix
  initial begin
    {fails, comparisons} = '0;
    {known, ep, eW, eF, eB} = {1'b1, 45'h0};
    {sys_rst, instrValid, instrWord, flagOverflow, flagZero} = {1'b1, 19'h0};
    {workingReg, statusReg, bankSelectReg, ov, zr, wr, sr, bank_select_reg} = '0;
    void'($urandom(32'h4D5BA353));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    call(20'hFFFFF, 1'b1);
    for (int i = 0; i < 12; i++) begin
      run_op(i % 6, i < 6 ? 8'h80 : 8'h7F);
      call(20'(i * 20'h11111), i[0]);
    end
    repeat (60) begin
      run_op($urandom % 6, 8'($urandom));
      call(20'($urandom), 1'($urandom));
    end
    end_sim();
  end
endmodule
